// file: elc_core_model.sv
// core-side partner model: counts event cycles and checks the wakeup line
`timescale 1ns/1ps
module elc_core_model (
	input  wire logic   clk_in,
	input  wire logic   srst_in,
	input  wire logic   irq_in,
	input  wire logic   event_in,
	input  wire logic   wakeup_in,
	output logic [15:0] event_cycles_out,
	output logic [15:0] wake_bad_out
);
	// counts high cycles, not edges, so a stretched pulse shows as extra counts
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			event_cycles_out <= 16'h0000;
		end else if (event_in === 1'b1) begin
			event_cycles_out <= event_cycles_out + 16'h0001;
		end
	end
	// a sleeping core wakes on either request, so wakeup must follow both
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wake_bad_out <= 16'h0000;
		end else if (wakeup_in !== (irq_in | event_in)) begin
			wake_bad_out <= wake_bad_out + 16'h0001;
		end
	end
endmodule

// file: elc_line_event_ctrl.sv
// external line event controller: edge detectors, masks, pending flags and axi4-lite registers
//
// Operation
// - there are 19 separate edge detector channels, 0 to 18, each able to raise an interrupt or event.
// - each channel can fire on a rising edge, a falling edge or both, as configured.
// - every channel's configuration and mask bits are written without touching other channels; here a write sets all channel bits of each strobed byte lane.
// - channels 0 to 15 take gpio pin n, 16 the supply voltage monitor, 17 the rtc alarm, 18 the usb wakeup.
// - the gpio port behind channels 0 to 15 is picked by the pin source selector outside this block.
// - the block drives per-channel interrupt requests and a separate event output for wait-for-event.
// - a valid trigger on an enabled channel raises a wakeup request for the sleeping system.
// - interrupt mask at 0x00, bits 18:0, a one lets the channel's interrupt request through.
// - event mask at 0x04, bits 18:0, a one lets the channel's trigger reach the event output.
// - rising trigger select at 0x08, a one makes a rising edge on that channel a valid request.
// - falling trigger select at 0x0C, a one makes a falling edge valid; both set gives both edges.
// - writing one to a software trigger bit at 0x10 raises a request on that channel, zero withdraws it; here zero clears the bit but not its pending flag.
// - pending flags at 0x14 are set when a channel triggers and stay set until cleared.
// - software clears a pending flag by writing one to it.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module elc_line_event_ctrl
	import elc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic                      clk_in,
	input  wire logic                      srst_in,
	input  wire logic                      ce_in,
	input  wire logic [ELC_GPIO_LINES-1:0] gpio_line_in,
	input  wire logic                      supply_voltage_monitor_in,
	input  wire logic                      rtc_alarm_in,
	input  wire logic                      usb_wakeup_in,
	input  wire logic [ADDR_W-1:0]         s_axi_awaddr_in,
	input  wire logic                      s_axi_awvalid_in,
	output logic                           s_axi_awready_out,
	input  wire logic [ELC_DATA_W-1:0]     s_axi_wdata_in,
	input  wire logic [ELC_STRB_W-1:0]     s_axi_wstrb_in,
	input  wire logic                      s_axi_wvalid_in,
	output logic                           s_axi_wready_out,
	output logic [1:0]                     s_axi_bresp_out,
	output logic                           s_axi_bvalid_out,
	input  wire logic                      s_axi_bready_in,
	input  wire logic [ADDR_W-1:0]         s_axi_araddr_in,
	input  wire logic                      s_axi_arvalid_in,
	output logic                           s_axi_arready_out,
	output logic [ELC_DATA_W-1:0]          s_axi_rdata_out,
	output logic [1:0]                     s_axi_rresp_out,
	output logic                           s_axi_rvalid_out,
	input  wire logic                      s_axi_rready_in,
	output logic [ELC_LINE_COUNT-1:0]      line_irq_out,
	output logic                           irq_out,
	output logic                           event_out,
	output logic                           wakeup_out
);

	localparam int RSVD_W = ELC_DATA_W - ELC_LINE_COUNT;

	// merge a write into a register, byte lane by byte lane; upper bits are dropped
	function automatic logic [ELC_LINE_COUNT-1:0] elc_merge(
		input logic [ELC_LINE_COUNT-1:0] old_v,
		input logic [ELC_DATA_W-1:0]     data,
		input logic [ELC_STRB_W-1:0]     strb
	);
		logic [ELC_DATA_W-1:0] res;
		res = {{RSVD_W{1'b0}}, old_v};
		for (int b = 0; b < ELC_STRB_W; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res[ELC_LINE_COUNT-1:0];
	endfunction

	// word match on an address; byte offset bits are ignored
	function automatic logic elc_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        offset
	);
		logic [ADDR_W-1:0] off_w;
		off_w = ADDR_W'(offset);
		return addr[ADDR_W-1:2] == off_w[ADDR_W-1:2];
	endfunction

	logic [ELC_LINE_COUNT-1:0] raw_line;
	logic [ELC_LINE_COUNT-1:0] line_meta_ff;
	logic [ELC_LINE_COUNT-1:0] line_q_ff;
	logic [ELC_LINE_COUNT-1:0] line_prev_ff;
	logic [ELC_LINE_COUNT-1:0] imask_ff;
	logic [ELC_LINE_COUNT-1:0] emask_ff;
	logic [ELC_LINE_COUNT-1:0] rise_ff;
	logic [ELC_LINE_COUNT-1:0] fall_ff;
	logic [ELC_LINE_COUNT-1:0] swtrig_ff;
	logic [ELC_LINE_COUNT-1:0] pend_ff;
	logic [ELC_LINE_COUNT-1:0] nxt_pend;
	logic [ELC_LINE_COUNT-1:0] nxt_swtrig;
	logic [ELC_LINE_COUNT-1:0] rise_hit;
	logic [ELC_LINE_COUNT-1:0] fall_hit;
	logic [ELC_LINE_COUNT-1:0] sw_hit;
	logic [ELC_LINE_COUNT-1:0] trig;
	logic [ELC_LINE_COUNT-1:0] pend_clr;
	logic                      event_ff;
	logic [ADDR_W-1:0]         aw_addr_ff;
	logic                      aw_hold_ff;
	logic [ELC_DATA_W-1:0]     w_data_ff;
	logic [ELC_STRB_W-1:0]     w_strb_ff;
	logic                      w_hold_ff;
	logic                      bvalid_ff;
	logic [1:0]                bresp_ff;
	logic                      rvalid_ff;
	logic [ELC_DATA_W-1:0]     rdata_ff;
	logic [1:0]                rresp_ff;
	logic                      wr_go;
	logic                      wr_mapped;
	logic                      wr_imask;
	logic                      wr_emask;
	logic                      wr_rise;
	logic                      wr_fall;
	logic                      wr_swtrig;
	logic                      wr_pend;
	logic [ELC_LINE_COUNT-1:0] wr_val;
	logic [ELC_DATA_W-1:0]     rd_word;
	logic                      rd_mapped;

	// gpio channels come already routed by the pin source selector
	assign raw_line = {usb_wakeup_in, rtc_alarm_in, supply_voltage_monitor_in, gpio_line_in};

	// two stages guard against pins toggling near the clock; costs two cycles of latency
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			line_meta_ff <= {ELC_LINE_COUNT{1'b0}};
			line_q_ff    <= {ELC_LINE_COUNT{1'b0}};
			line_prev_ff <= {ELC_LINE_COUNT{1'b0}};
		end else if (ce_in) begin
			line_meta_ff <= raw_line;
			line_q_ff    <= line_meta_ff;
			line_prev_ff <= line_q_ff;
		end
	end

	assign rise_hit = line_q_ff & ~line_prev_ff & rise_ff;
	assign fall_hit = ~line_q_ff & line_prev_ff & fall_ff;

	// write channel decode
	assign wr_go     = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign wr_imask  = wr_go & elc_hit(aw_addr_ff, ELC_OFF_IMASK);
	assign wr_emask  = wr_go & elc_hit(aw_addr_ff, ELC_OFF_EMASK);
	assign wr_rise   = wr_go & elc_hit(aw_addr_ff, ELC_OFF_RISE);
	assign wr_fall   = wr_go & elc_hit(aw_addr_ff, ELC_OFF_FALL);
	assign wr_swtrig = wr_go & elc_hit(aw_addr_ff, ELC_OFF_SWTRIG);
	assign wr_pend   = wr_go & elc_hit(aw_addr_ff, ELC_OFF_PEND);
	assign wr_mapped = wr_imask | wr_emask | wr_rise | wr_fall | wr_swtrig | wr_pend;

	// only the low 19 bits are kept
	assign wr_val = elc_merge({ELC_LINE_COUNT{1'b0}}, w_data_ff, w_strb_ff);

	// software request fires on a bit going from zero to one
	assign sw_hit   = wr_swtrig ? (elc_merge(swtrig_ff, w_data_ff, w_strb_ff) & ~swtrig_ff)
	                            : {ELC_LINE_COUNT{1'b0}};
	assign trig     = rise_hit | fall_hit | sw_hit;
	assign pend_clr = wr_pend ? wr_val : {ELC_LINE_COUNT{1'b0}};

	// a trigger in the clearing cycle wins, so no edge is lost
	assign nxt_pend = (pend_ff & ~pend_clr) | trig;

	// clearing a pending flag also drops its software request so it can be raised again
	always_comb begin
		nxt_swtrig = swtrig_ff;
		if (wr_swtrig) begin
			nxt_swtrig = elc_merge(swtrig_ff, w_data_ff, w_strb_ff);
		end
		nxt_swtrig = nxt_swtrig & ~pend_clr;
	end

	// each register written on its own, per byte lane
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			imask_ff <= ELC_RST_IMASK;
		end else if (ce_in && wr_imask) begin
			imask_ff <= elc_merge(imask_ff, w_data_ff, w_strb_ff);
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			emask_ff <= ELC_RST_EMASK;
		end else if (ce_in && wr_emask) begin
			emask_ff <= elc_merge(emask_ff, w_data_ff, w_strb_ff);
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rise_ff <= ELC_RST_RISE;
		end else if (ce_in && wr_rise) begin
			rise_ff <= elc_merge(rise_ff, w_data_ff, w_strb_ff);
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			fall_ff <= ELC_RST_FALL;
		end else if (ce_in && wr_fall) begin
			fall_ff <= elc_merge(fall_ff, w_data_ff, w_strb_ff);
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			swtrig_ff <= ELC_RST_SWTRIG;
		end else if (ce_in) begin
			swtrig_ff <= nxt_swtrig;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pend_ff <= ELC_RST_PEND;
		end else if (ce_in) begin
			pend_ff <= nxt_pend;
		end
	end

	// event pulse is registered so it lasts exactly one enabled cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			event_ff <= 1'b0;
		end else if (ce_in) begin
			event_ff <= |(trig & emask_ff);
		end
	end

	assign line_irq_out = pend_ff & imask_ff;
	assign irq_out      = |line_irq_out;
	assign event_out    = event_ff;
	assign wakeup_out   = irq_out | event_ff;

	// axi4-lite write: address and data captured independently, then one response
	assign s_axi_awready_out = ~aw_hold_ff & ~bvalid_ff;
	assign s_axi_wready_out  = ~w_hold_ff & ~bvalid_ff;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			aw_hold_ff <= 1'b0;
			aw_addr_ff <= {ADDR_W{1'b0}};
		end else if (ce_in) begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr_in;
			end else if (wr_go) begin
				aw_hold_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			w_hold_ff <= 1'b0;
			w_data_ff <= {ELC_DATA_W{1'b0}};
			w_strb_ff <= {ELC_STRB_W{1'b0}};
		end else if (ce_in) begin
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= s_axi_wdata_in;
				w_strb_ff <= s_axi_wstrb_in;
			end else if (wr_go) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= ELC_RESP_OKAY;
		end else if (ce_in) begin
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_mapped ? ELC_RESP_OKAY : ELC_RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid_out = bvalid_ff;
	assign s_axi_bresp_out  = bresp_ff;

	// axi4-lite read: one outstanding read, answered the cycle after it is taken
	assign s_axi_arready_out = ~rvalid_ff;

	always_comb begin
		rd_word   = {ELC_DATA_W{1'b0}};
		rd_mapped = 1'b1;
		if (elc_hit(s_axi_araddr_in, ELC_OFF_IMASK)) begin
			rd_word = {{RSVD_W{1'b0}}, imask_ff};
		end else if (elc_hit(s_axi_araddr_in, ELC_OFF_EMASK)) begin
			rd_word = {{RSVD_W{1'b0}}, emask_ff};
		end else if (elc_hit(s_axi_araddr_in, ELC_OFF_RISE)) begin
			rd_word = {{RSVD_W{1'b0}}, rise_ff};
		end else if (elc_hit(s_axi_araddr_in, ELC_OFF_FALL)) begin
			rd_word = {{RSVD_W{1'b0}}, fall_ff};
		end else if (elc_hit(s_axi_araddr_in, ELC_OFF_SWTRIG)) begin
			rd_word = {{RSVD_W{1'b0}}, swtrig_ff};
		end else if (elc_hit(s_axi_araddr_in, ELC_OFF_PEND)) begin
			rd_word = {{RSVD_W{1'b0}}, pend_ff};
		end else begin
			rd_mapped = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= {ELC_DATA_W{1'b0}};
			rresp_ff  <= ELC_RESP_OKAY;
		end else if (ce_in) begin
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_word;
				rresp_ff  <= rd_mapped ? ELC_RESP_OKAY : ELC_RESP_SLVERR;
			end else if (s_axi_rready_in) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid_out = rvalid_ff;
	assign s_axi_rdata_out  = rdata_ff;
	assign s_axi_rresp_out  = rresp_ff;

	// checks; every trigger except pend_sticky_a is gated by the clock enable because state freezes without it
	default clocking elc_cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	sequence rise_seen_s;
		ce_in && ((line_q_ff & ~line_prev_ff & rise_ff) != {ELC_LINE_COUNT{1'b0}});
	endsequence

	sequence fall_seen_s;
		ce_in && ((~line_q_ff & line_prev_ff & fall_ff) != {ELC_LINE_COUNT{1'b0}});
	endsequence

	sequence sw_set_s;
		ce_in && (sw_hit != {ELC_LINE_COUNT{1'b0}});
	endsequence

	sequence wr_pair_s;
		ce_in && aw_hold_ff && w_hold_ff && !bvalid_ff;
	endsequence

	rise_pend_a: assert property (
		rise_seen_s |=> ((pend_ff & $past(rise_hit)) == $past(rise_hit)))
		else $error("rising edge did not set pending flag");

	fall_pend_a: assert property (
		fall_seen_s |=> ((pend_ff & $past(fall_hit)) == $past(fall_hit)))
		else $error("falling edge did not set pending flag");

	sw_pend_a: assert property (
		sw_set_s |=> ((pend_ff & $past(sw_hit)) == $past(sw_hit)))
		else $error("software trigger did not set pending flag");

	pend_sticky_a: assert property (
		(!wr_pend || !ce_in) |=> ((pend_ff & $past(pend_ff)) == $past(pend_ff)))
		else $error("pending flag fell without a clear");

	pend_clear_a: assert property (
		(ce_in && wr_pend) |=> ((pend_ff & $past(wr_val) & ~$past(trig)) == {ELC_LINE_COUNT{1'b0}}))
		else $error("pending flag not cleared by write of one");

	pend_zero_a: assert property (
		(ce_in && wr_pend) |=> ((pend_ff & ~$past(wr_val)) == (($past(pend_ff) | $past(trig)) & ~$past(wr_val))))
		else $error("writing zero changed a pending flag");

	irq_gate_a: assert property (
		(ce_in && wr_imask && (wr_val == {ELC_LINE_COUNT{1'b0}}) && (w_strb_ff[2:0] == 3'h7))
		|=> !irq_out)
		else $error("masked channel still drives interrupt");

	event_pulse_a: assert property (
		(ce_in && ((trig & emask_ff) != {ELC_LINE_COUNT{1'b0}})) |=> event_out ##1 (!event_out || $past(ce_in) && $past((trig & emask_ff) != {ELC_LINE_COUNT{1'b0}}) || !$past(ce_in)))
		else $error("event output is not a single pulse");

	wake_a: assert property (
		(ce_in && ((trig & (imask_ff | emask_ff)) != {ELC_LINE_COUNT{1'b0}})) |=> wakeup_out)
		else $error("enabled trigger gave no wakeup");

	wr_resp_a: assert property (
		wr_pair_s |=> s_axi_bvalid_out ##0 (s_axi_bvalid_out && !s_axi_awready_out && !s_axi_wready_out))
		else $error("write not answered the cycle after both halves");

	rd_rsvd_a: assert property (
		(ce_in && s_axi_arvalid_in && s_axi_arready_out) |=> (s_axi_rvalid_out && (s_axi_rdata_out[31:19] == 13'h0)))
		else $error("read answer late or reserved bits set");

endmodule

// file: elc_pkg.sv
// constants shared by the external line event controller
package elc_pkg;
	localparam int          ELC_LINE_COUNT   = 19;
	localparam int          ELC_GPIO_LINES   = 16;
	localparam int          ELC_LINE_VMON    = 16;
	localparam int          ELC_LINE_RTC     = 17;
	localparam int          ELC_LINE_USB     = 18;
	localparam int          ELC_DATA_W       = 32;
	localparam int          ELC_STRB_W       = 4;

	localparam logic [7:0]  ELC_OFF_IMASK    = 8'h00;
	localparam logic [7:0]  ELC_OFF_EMASK    = 8'h04;
	localparam logic [7:0]  ELC_OFF_RISE     = 8'h08;
	localparam logic [7:0]  ELC_OFF_FALL     = 8'h0C;
	localparam logic [7:0]  ELC_OFF_SWTRIG   = 8'h10;
	localparam logic [7:0]  ELC_OFF_PEND     = 8'h14;

	localparam logic [18:0] ELC_RST_IMASK    = 19'h00000;
	localparam logic [18:0] ELC_RST_EMASK    = 19'h00000;
	localparam logic [18:0] ELC_RST_RISE     = 19'h00000;
	localparam logic [18:0] ELC_RST_FALL     = 19'h00000;
	localparam logic [18:0] ELC_RST_SWTRIG   = 19'h00000;
	localparam logic [18:0] ELC_RST_PEND     = 19'h00000;

	localparam logic [1:0]  ELC_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  ELC_RESP_SLVERR  = 2'h2;
endpackage

// file: tb_external_line_event_controller.sv
// self-checking bench for the external line event controller
`timescale 1ns/1ps
module tb_external_line_event_controller
	import elc_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [15:0] gpio = 16'h0000;
	logic        vmon = 1'b0;
	logic        rtc = 1'b0;
	logic        usb = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        ce = 1'b1;
	logic        awready, wready, bvalid, arready, rvalid, irq, evt, wake;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [18:0] line_irq;
	logic [15:0] ev_cnt, wk_bad;
	logic [31:0] rng = 32'h00017C89;
	int          num_errors = 0;
	int          check_count = 0;
	int          cycles = 0;

	always #2 clk_in = ~clk_in;

	elc_line_event_ctrl #(.ADDR_W(8)) i_dut (
		.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce), .gpio_line_in(gpio),
		.supply_voltage_monitor_in(vmon), .rtc_alarm_in(rtc), .usb_wakeup_in(usb),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .line_irq_out(line_irq),
		.irq_out(irq), .event_out(evt), .wakeup_out(wake)
	);

	elc_core_model i_core (
		.clk_in(clk_in), .srst_in(srst_in), .irq_in(irq), .event_in(evt),
		.wakeup_in(wake), .event_cycles_out(ev_cnt), .wake_bad_out(wk_bad)
	);

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask

	// a hung handshake ends the run rather than stalling every later test
	task automatic guard(input int n);
		if (n >= 100) begin
			$display("mismatch handshake expected answer seen none");
			num_errors++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_in);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		guard(n);
		// bready stays high between writes so back-to-back calls never assign it twice in one step
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_in);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		guard(n);
		chk("rdata", exp, rdata);
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	task automatic set_line(input int x, input logic v);
		if (x < ELC_GPIO_LINES) gpio[x] <= v;
		else if (x == ELC_LINE_VMON) vmon <= v;
		else if (x == ELC_LINE_RTC) rtc <= v;
		else usb <= v;
	endtask

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			$display("mismatch timeout expected finish seen hang");
			num_errors++;
			report_and_stop();
		end
	end

	initial begin
		int i, x, m, v;
		logic [31:0] a, b, e, c;
		logic [31:0] sh[5];
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		for (i = 0; i < 6; i++) rdchk(8'(i * 4), 32'h0, ELC_RESP_OKAY);
		rdchk(8'h18, 32'h0, ELC_RESP_SLVERR);
		wr(8'h18, 32'hFFFFFFFF, ELC_RESP_SLVERR);
		$display("test reset_values done");
		for (i = 0; i < 5; i++) sh[i] = 32'h0;
		for (i = 0; i < 20; i++) begin
			a = (xs() % 5) * 4;
			b = xs();
			sh[a[4:2]] = b & 32'h0007FFFF;
			wr(a[7:0], b, ELC_RESP_OKAY);
			rdchk(a[7:0], sh[a[4:2]], ELC_RESP_OKAY);
		end
		for (i = 0; i < 5; i++) rdchk(8'(i * 4), sh[i], ELC_RESP_OKAY);
		for (i = 0; i < 5; i++) wr(8'(i * 4), 32'h0, ELC_RESP_OKAY);
		wr(8'h14, 32'hFFFFFFFF, ELC_RESP_OKAY);
		rdchk(8'h14, 32'h0, ELC_RESP_OKAY);
		$display("test register_access done");
		// line x uses mode x mod 3: rising only, falling only, both
		for (x = 0; x < ELC_LINE_COUNT; x++) begin
			m = x % 3;
			b = 32'h1 << x;
			wr(8'h08, (m != 1) ? b : 32'h0, ELC_RESP_OKAY);
			wr(8'h0C, (m != 0) ? b : 32'h0, ELC_RESP_OKAY);
			wr(8'h00, b, ELC_RESP_OKAY);
			for (v = 1; v >= 0; v--) begin
				set_line(x, v[0]);
				repeat (5) @(posedge clk_in);
				e = ((v == 1) ? (m != 1) : (m != 0)) ? b : 32'h0;
				chk("line_irq", e, 32'(line_irq));
				rdchk(8'h14, e, ELC_RESP_OKAY);
				wr(8'h14, b, ELC_RESP_OKAY);
				rdchk(8'h14, 32'h0, ELC_RESP_OKAY);
			end
		end
		$display("test edge_detect done");
		for (i = 0; i < 8; i++) begin
			x = xs() % ELC_LINE_COUNT;
			b = 32'h1 << x;
			wr(8'h00, 32'h0, ELC_RESP_OKAY);
			wr(8'h04, i[0] ? b : 32'h0, ELC_RESP_OKAY);
			c = 32'(ev_cnt);
			wr(8'h10, b, ELC_RESP_OKAY);
			repeat (3) @(posedge clk_in);
			chk("event_cycles", i[0] ? c + 1 : c, 32'(ev_cnt));
			chk("irq_masked", 32'h0, 32'(irq));
			rdchk(8'h14, b, ELC_RESP_OKAY);
			wr(8'h00, b, ELC_RESP_OKAY);
			@(posedge clk_in);
			chk("irq", 32'h1, 32'(irq));
			chk("wakeup", 32'h1, 32'(wake));
			wr(8'h14, 32'h0, ELC_RESP_OKAY);
			rdchk(8'h14, b, ELC_RESP_OKAY);
			wr(8'h14, b, ELC_RESP_OKAY);
			@(posedge clk_in);
			chk("irq_cleared", 32'h0, 32'(irq));
		end
		chk("wake_model", 32'h0, 32'(wk_bad));
		$display("test software_trigger done");
		// partial strobe touches only its byte lane
		wr(8'h00, 32'hFFFFFFFF, ELC_RESP_OKAY);
		wstrb <= 4'h2;
		wr(8'h00, 32'h0, ELC_RESP_OKAY);
		wstrb <= 4'hF;
		rdchk(8'h00, 32'h000700FF, ELC_RESP_OKAY);
		// an edge that arrives while the enable is low must wait until it returns
		wr(8'h08, 32'h1, ELC_RESP_OKAY);
		wr(8'h0C, 32'h0, ELC_RESP_OKAY);
		wr(8'h00, 32'h1, ELC_RESP_OKAY);
		ce <= 1'b0;
		set_line(0, 1'b1);
		repeat (6) @(posedge clk_in);
		chk("line_irq_frozen", 32'h0, 32'(line_irq));
		ce <= 1'b1;
		repeat (5) @(posedge clk_in);
		chk("line_irq_resumed", 32'h1, 32'(line_irq));
		set_line(0, 1'b0);
		wr(8'h14, 32'h1, ELC_RESP_OKAY);
		rdchk(8'h14, 32'h0, ELC_RESP_OKAY);
		$display("test clock_enable done");
		report_and_stop();
	end
endmodule
